/* design/ccarr_top.v */
// Purpose: capture/compare channels with shared 16-bit counter and flags
// Assumes: byte register port; pins synchronous to mclk; tick from outside
// Notes:   counter advances on timebase_tick when the run bit is set
//          pin edges need two samples of each level, so a one-cycle blip
//          is dropped; irq trails flags by a cycle and channel irq enables by two; pin enables trail by a cycle
//
// Behaviour
// [RULE1] Counter wrap flag sets when the 16-bit counter wraps.
// [RULE2] Partial wrap flag sets on overflow of the selected 8-11 bit length.
// [RULE3] Flags set on their trigger regardless of interrupt enables.
// [RULE4] Interrupt request is any enabled flag, gated by global and block enables.
// [RULE5] Rise-only or fall-only capture with match, invert and pulse bits clear.
// [RULE6] Both selects set capture on either pin transition.
// [RULE7] Qualified edge loads the counter into compare and sets channel flag.
// [RULE8] Pin levels must last two clocks to be seen.
// [RULE9] Channel flags stay set until software clears them.
// [RULE10] Software timer flags when counter equals compare register.
// [RULE11] Low byte write clears comparator enable, high byte write sets it.
// [RULE12] Toggle mode inverts pin and flags on every match.
// [RULE13] Toggle mode with comparator off holds the pin level.
// [RULE14] Frequency mode matches low bytes, toggles, adds high byte to low byte.
// [RULE15] High byte zero means a half period of 256 ticks.
// [RULE16] Frequency mode flags only on full 16-bit equality with match enabled.
// [RULE17] Pulse modes: 8-11 bit by cycle length code, 16 bit with wide select.
// [RULE18] All 8-11 bit pulse channels share one cycle length.
// [RULE19] Pulse modes with comparator off hold output low.
// [RULE20] Reload view select steers byte access to reload register in 9-11 bit.
// [RULE21] Pulse modes with match enable flag on each match.
// [RULE22] Counter wrap is the step from all ones to all zeros.
// [RULE23] Everything on mclk; matches evaluated only on counter ticks.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "ccarr_regs.vh"

module ccarr_top #(
   parameter NCH = 6
) (
   input  wire             mclk,
   input  wire             resetn,
   input  wire [7:0]       reg_addr,
   input  wire [7:0]       reg_wdata,
   input  wire             reg_wr,
   input  wire             reg_rd,
   output reg  [7:0]       reg_rdata,
   input  wire             timebase_tick,
   input  wire [NCH-1:0]   channel_pin_in,
   output reg  [NCH-1:0]   channel_pin_out,
   output reg  [NCH-1:0]   channel_pin_oe,
   output reg              irq
);

   // Shared state
   reg  [7:0]        ctrl_r;
   reg  [7:0]        pwmcfg_r;
   reg  [15:0]       cnt_r;
   reg               wrap_flag_r;
   reg               pwrap_flag_r;
   reg  [NCH-1:0]    chan_flag_r;
   reg  [NCH-1:0]    chan_ien_r;
   reg  [NCH-1:0]    pin_d1_r;
   reg  [NCH-1:0]    pin_d2_r;
   reg  [NCH-1:0]    pin_d3_r;
   reg  [NCH-1:0]    pin_d4_r;
   reg  [7:0]        mode_r   [0:NCH-1];
   reg  [15:0]       cmp_r    [0:NCH-1];
   reg  [15:0]       rld_r    [0:NCH-1];

   wire              tick;
   wire [15:0]       cnt_nxt;
   wire [1:0]        cycle_length_select;
   wire              reload_view_select;
   reg               pwrap_evt;
   reg  [NCH-1:0]    chan_evt;
   reg  [7:0]        rdata_nxt;
   integer           i;
   integer           k;
   wire              flags_wr;

   // Channel register decode, reused by writes and reads
   function ch_hit;
      input [7:0] addr;
      input integer ch;
      input [1:0] sel;
      begin
         ch_hit = (addr == (`CCA_CH_BASE + {ch[5:0], sel}));
      end
   endfunction

   // Mask of counter bits used by an N-bit pulse length
   function [15:0] len_mask;
      input [1:0] code;
      begin
         len_mask = {5'h00, code == 2'h3, code >= 2'h2, code >= 2'h1, 8'hff};
      end
   endfunction

   // Qualified pin edge: two samples of the new level after two of the old
   // one, so a level shorter than two clocks never counts in either direction
   function edge_seen;
      input new_a;
      input new_b;
      input old_a;
      input old_b;
      input to_high;
      begin
         if (to_high)
            edge_seen = new_a & new_b & ~old_a & ~old_b;
         else
            edge_seen = ~new_a & ~new_b & old_a & old_b;
      end
   endfunction

   // [RULE23] tick gated
   assign tick    = timebase_tick & ctrl_r[`CCA_CTRL_RUN];
   assign cnt_nxt = cnt_r + 16'h0001;
   // [RULE18] shared length
   assign cycle_length_select   = pwmcfg_r[`CCA_PWM_CYCLE_LENGTH_SELECT_LO+1:`CCA_PWM_CYCLE_LENGTH_SELECT_LO];
   assign reload_view_select   = pwmcfg_r[`CCA_PWM_RELOAD_VIEW_SELECT];
   // Flag clear strobe, shared by every write-one-to-clear bit
   assign flags_wr = reg_wr & (reg_addr == `CCA_FLAGS_OFF);

   // Partial wrap: all bits up to the selected length are ones on a tick
   always @* begin
      // [RULE2] partial overflow detect
      pwrap_evt = tick & ((cnt_r & len_mask(cycle_length_select)) == len_mask(cycle_length_select));
   end

   // Shared counter, control and wrap flags
   // Byte writes to the counter are not paired; software that writes a
   // running counter may see a carry between the two bytes
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r       <= `CCA_RST_BYTE;
         pwmcfg_r     <= `CCA_RST_BYTE;
         cnt_r        <= `CCA_RST_WORD;
         wrap_flag_r  <= 1'b0;
         pwrap_flag_r <= 1'b0;
         chan_ien_r   <= {NCH{1'b0}};
      end else begin
         if (reg_wr && reg_addr == `CCA_CTRL_OFF)
            ctrl_r <= reg_wdata;
         if (reg_wr && reg_addr == `CCA_PWMCFG_OFF)
            pwmcfg_r <= reg_wdata;
         // Software write to the counter takes priority over a tick
         if (reg_wr && reg_addr == `CCA_CNTL_OFF)
            cnt_r[7:0] <= reg_wdata;
         else if (reg_wr && reg_addr == `CCA_CNTH_OFF)
            cnt_r[15:8] <= reg_wdata;
         else if (tick)
            cnt_r <= cnt_nxt;
         // [RULE1] [RULE22] wrap set wins over clear
         if (tick && cnt_r == `CCA_ONES_WORD)
            wrap_flag_r <= 1'b1;
         else if (flags_wr && reg_wdata[`CCA_FLG_WRAP])
            wrap_flag_r <= 1'b0;
         // [RULE2] [RULE3] partial wrap set wins
         if (pwrap_evt)
            pwrap_flag_r <= 1'b1;
         else if (flags_wr && reg_wdata[`CCA_FLG_PWRAP])
            pwrap_flag_r <= 1'b0;
         for (i = 0; i < NCH; i = i + 1)
            chan_ien_r[i] <= mode_r[i][`CCA_M_IRQEN];
      end
   end

   // Pin sampling: pins are synchronous, four stages give edge history.
   // Two stages hold the new level and two the old one; with only three,
   // a one-cycle blip would pass as a falling edge right after it.
   // Reset level low matches an idle low pin, so no false edge follows.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pin_d1_r <= {NCH{1'b0}};
         pin_d2_r <= {NCH{1'b0}};
         pin_d3_r <= {NCH{1'b0}};
         pin_d4_r <= {NCH{1'b0}};
      end else begin
         pin_d1_r <= channel_pin_in;
         pin_d2_r <= pin_d1_r;
         pin_d3_r <= pin_d2_r;
         pin_d4_r <= pin_d3_r;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_ch
         // Mode bits split out; each mode below is a full decode so that
         // a half-written mode byte never mixes two behaviours
         wire [7:0]  m     = mode_r[g];
         wire        ecom  = m[`CCA_M_ECOM];
         wire        rise  = m[`CCA_M_RISE];
         wire        fall  = m[`CCA_M_FALL];
         wire        mat   = m[`CCA_M_MAT];
         wire        tog   = m[`CCA_M_TOG];
         wire        pwm   = m[`CCA_M_PWM];
         wire        wide  = m[`CCA_M_WIDE];
         // [RULE8] stable level seen on two samples before the change
         wire        p_rise = edge_seen(pin_d1_r[g], pin_d2_r[g], pin_d3_r[g],
                                        pin_d4_r[g], 1'b1);
         wire        p_fall = edge_seen(pin_d1_r[g], pin_d2_r[g], pin_d3_r[g],
                                        pin_d4_r[g], 1'b0);
         // [RULE5] [RULE6] capture qualify
         wire        cap_mode = ~mat & ~tog & ~pwm;
         wire        cap_evt  = cap_mode & ((rise & p_rise) | (fall & p_fall));
         wire        full_eq  = tick & (cnt_r == cmp_r[g]);
         wire        timer_md = ~pwm & ~rise & ~fall & ecom;
         wire        freq_md  = pwm & tog & ~rise & ~fall;
         wire        pwm_md   = pwm & ~tog & ~rise & ~fall;
         // [RULE17] length: 16 bit when wide, else shared code
         wire [15:0] msk      = wide ? `CCA_ONES_WORD : len_mask(cycle_length_select);
         wire        pwm_eq   = tick & ecom & ((cnt_r & msk) == (cmp_r[g] & msk));
         wire        pwm_ovf  = wide ? (tick && cnt_r == `CCA_ONES_WORD) : pwrap_evt;
         wire        freq_eq  = tick & ecom & (cnt_r[7:0] == cmp_r[g][7:0]);
         // [RULE20] reload view for writes only in 9-11 bit pulse mode; reads follow the select whenever the length code is nonzero
         wire        use_rld  = reload_view_select & pwm_md & ~wide & (cycle_length_select != 2'h0);
         wire        wr_lo    = reg_wr & ch_hit(reg_addr, g, `CCA_CH_LOW);
         wire        wr_hi    = reg_wr & ch_hit(reg_addr, g, `CCA_CH_HIGH);

         // Event for the channel flag, per mode
         always @* begin
            chan_evt[g] = 1'b0;
            // [RULE7] capture flags
            if (cap_evt)
               chan_evt[g] = 1'b1;
            // [RULE10] [RULE12] timer and toggle match
            if (timer_md & mat & full_eq)
               chan_evt[g] = 1'b1;
            // [RULE16] frequency full match
            if (freq_md & mat & full_eq)
               chan_evt[g] = 1'b1;
            // [RULE21] pulse match flag
            if (pwm_md & mat & pwm_eq)
               chan_evt[g] = 1'b1;
         end

         // Channel mode, compare and reload registers, pin output
         always @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               mode_r[g]          <= `CCA_RST_BYTE;
               cmp_r[g]           <= `CCA_RST_WORD;
               rld_r[g]           <= `CCA_RST_WORD;
               channel_pin_out[g] <= 1'b0;
               channel_pin_oe[g]  <= 1'b0;
            end else begin
               // [RULE11] low clears, high sets comparator enable
               if (reg_wr && ch_hit(reg_addr, g, `CCA_CH_MODE))
                  mode_r[g] <= reg_wdata;
               else if (wr_lo)
                  mode_r[g][`CCA_M_ECOM] <= 1'b0;
               else if (wr_hi)
                  mode_r[g][`CCA_M_ECOM] <= 1'b1;
               // Drive pin in output modes only
               channel_pin_oe[g] <= ~cap_mode & (tog | pwm);
               if (cap_evt) begin
                  cmp_r[g] <= cnt_r;
               end else if (wr_lo && use_rld) begin
                  rld_r[g][7:0] <= reg_wdata;
               end else if (wr_hi && use_rld) begin
                  rld_r[g][15:8] <= reg_wdata;
               end else if (wr_lo) begin
                  cmp_r[g][7:0] <= reg_wdata;
               end else if (wr_hi) begin
                  cmp_r[g][15:8] <= reg_wdata;
               end else if (freq_md && freq_eq) begin
                  // [RULE14] [RULE15] add half period; 0 wraps to 256
                  cmp_r[g][7:0] <= cmp_r[g][7:0] + cmp_r[g][15:8];
               end else if (pwm_md && !wide && pwm_ovf) begin
                  // Reload at overflow edge: 8 bit from high byte
                  if (cycle_length_select == 2'h0)
                     cmp_r[g][7:0] <= cmp_r[g][15:8];
                  else
                     cmp_r[g] <= rld_r[g];
               end
               // [RULE12] [RULE13] toggle only while enabled
               if (timer_md && tog && mat && full_eq)
                  channel_pin_out[g] <= ~channel_pin_out[g];
               else if (freq_md && freq_eq)
                  channel_pin_out[g] <= ~channel_pin_out[g];
               else if (pwm_md) begin
                  // [RULE19] comparator off holds low
                  if (!ecom)
                     channel_pin_out[g] <= 1'b0;
                  else if (pwm_eq)
                     channel_pin_out[g] <= 1'b1;
                  else if (pwm_ovf)
                     channel_pin_out[g] <= 1'b0;
               end
            end
         end

         // [RULE3] [RULE9] sticky flag, set beats clear
         always @(posedge mclk or negedge resetn) begin
            if (!resetn)
               chan_flag_r[g] <= 1'b0;
            else if (chan_evt[g])
               chan_flag_r[g] <= 1'b1;
            else if (flags_wr && reg_wdata[g])
               chan_flag_r[g] <= 1'b0;
         end
      end
   endgenerate

   // Read mux, selected registers map through the channel decode.
   // Own loop index: sharing one with the clocked loop would give it
   // two drivers and a race between the processes.
   always @* begin
      rdata_nxt = 8'h00;
      case (reg_addr)
         `CCA_CTRL_OFF:   rdata_nxt = ctrl_r;
         `CCA_PWMCFG_OFF: rdata_nxt = pwmcfg_r;
         `CCA_CNTL_OFF:   rdata_nxt = cnt_r[7:0];
         `CCA_CNTH_OFF:   rdata_nxt = cnt_r[15:8];
         `CCA_FLAGS_OFF: begin
            rdata_nxt[NCH-1:0]      = chan_flag_r;
            rdata_nxt[`CCA_FLG_WRAP]  = wrap_flag_r;
            rdata_nxt[`CCA_FLG_PWRAP] = pwrap_flag_r;
         end
         default: begin
            for (k = 0; k < NCH; k = k + 1) begin
               if (ch_hit(reg_addr, k, `CCA_CH_MODE))
                  rdata_nxt = mode_r[k];
               if (ch_hit(reg_addr, k, `CCA_CH_LOW))
                  rdata_nxt = (reload_view_select && cycle_length_select != 2'h0) ? rld_r[k][7:0] : cmp_r[k][7:0];
               if (ch_hit(reg_addr, k, `CCA_CH_HIGH))
                  rdata_nxt = (reload_view_select && cycle_length_select != 2'h0) ? rld_r[k][15:8] : cmp_r[k][15:8];
            end
         end
      endcase
   end

   // Read data one cycle later; idle value zero
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
         irq       <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
         // [RULE4] combined request
         // Registered for a clean output; costs one cycle after the flag
         irq <= ctrl_r[`CCA_CTRL_GLBEN] & ctrl_r[`CCA_CTRL_BLKEN] &
                ((wrap_flag_r & ctrl_r[`CCA_CTRL_WRAPEN]) |
                 (pwrap_flag_r & ctrl_r[`CCA_CTRL_PWRAPEN]) |
                 (|(chan_flag_r & chan_ien_r)));
      end
   end

endmodule

/* design/ccarr_regs.vh */
// Purpose: register map and field layout of the capture/compare array
// Assumes: byte-wide register port, offsets are byte addresses
// Notes:   one block of four addresses per channel starting at CH_BASE, three of them used
`ifndef CCARR_REGS_VH
`define CCARR_REGS_VH

// Shared registers
`define CCA_CTRL_OFF      8'h00
`define CCA_PWMCFG_OFF    8'h01
`define CCA_CNTL_OFF      8'h02
`define CCA_CNTH_OFF      8'h03
`define CCA_IRQEN_OFF     8'h04
`define CCA_FLAGS_OFF     8'h05
// Channel n: mode at CH_BASE+4n, low byte +1, high byte +2
`define CCA_CH_BASE       8'h10
`define CCA_CH_MODE       2'h0
`define CCA_CH_LOW        2'h1
`define CCA_CH_HIGH       2'h2

// Control register fields
`define CCA_CTRL_RUN      0
`define CCA_CTRL_BLKEN    1
`define CCA_CTRL_GLBEN    2
`define CCA_CTRL_WRAPEN   3
`define CCA_CTRL_PWRAPEN  4
// Pulse config fields
`define CCA_PWM_CYCLE_LENGTH_SELECT_LO  0
`define CCA_PWM_RELOAD_VIEW_SELECT     7
// Flags register fields (write 1 to clear)
`define CCA_FLG_WRAP      6
`define CCA_FLG_PWRAP     7
// Channel mode fields
`define CCA_M_IRQEN       0
`define CCA_M_PWM         1
`define CCA_M_TOG         2
`define CCA_M_MAT         3
`define CCA_M_FALL        4
`define CCA_M_RISE        5
`define CCA_M_ECOM        6
`define CCA_M_WIDE        7

`define CCA_RST_BYTE      8'h00
`define CCA_RST_WORD      16'h0000
`define CCA_ONES_WORD     16'hffff

`endif

/* dv/ccarr_assertions.sv */
// Purpose: port-level checks on the capture/compare array
// Assumes: one mclk domain, resetn async active low
// Notes:   outputs other than read data move only after ticks, writes or pin moves
`timescale 1ns/1ps
module ccarr_chk #(
   parameter NCH = 6
) (
   input wire           mclk,
   input wire           resetn,
   input wire [7:0]     reg_addr,
   input wire [7:0]     reg_wdata,
   input wire           reg_wr,
   input wire           reg_rd,
   input wire [7:0]     reg_rdata,
   input wire           timebase_tick,
   input wire [NCH-1:0] channel_pin_in,
   input wire [NCH-1:0] channel_pin_out,
   input wire [NCH-1:0] channel_pin_oe,
   input wire           irq
);
   reg [3:0]     quiet_r;
   reg [NCH-1:0] pin_q_r;
   // Cycles since any cause of output motion, saturating
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         quiet_r <= 4'h0;
         pin_q_r <= {NCH{1'b0}};
      end else begin
         pin_q_r <= channel_pin_in;
         if (timebase_tick || reg_wr || channel_pin_in != pin_q_r)
            quiet_r <= 4'h0;
         else if (quiet_r != 4'hf)
            quiet_r <= quiet_r + 4'h1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data seen without a read");
   AST_RESET_OUT: assert property ($rose(resetn) |-> !irq && channel_pin_oe == 0
      && channel_pin_out == 0) else $error("outputs not idle after reset");
   AST_IRQ_FALL: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
      else $error("irq dropped without a write");
   AST_IRQ_HOLD: assert property (irq && !reg_wr && !$past(reg_wr) ##1 !reg_wr |=> irq)
      else $error("irq not held while flags stand");
   AST_IRQ_CAUSE: assert property ($rose(irq) |-> quiet_r < 4'h6)
      else $error("irq rose with no cause");
   AST_OE_MODE: assert property ($changed(channel_pin_oe) |-> $past(reg_wr)
      || $past(reg_wr, 2)) else $error("pin enable moved without a mode write");
   AST_PIN_CAUSE: assert property ($changed(channel_pin_out) |-> $past(timebase_tick)
      || $past(timebase_tick, 2) || $past(reg_wr) || $past(reg_wr, 2))
      else $error("pin moved without tick or write");
   AST_QUIET: assert property (quiet_r >= 4'h6 |->
      $stable(channel_pin_out) && $stable(irq)) else $error("outputs moved while idle");
endmodule
bind ccarr_top ccarr_chk #(.NCH(NCH)) chk_u (.mclk(mclk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .timebase_tick(timebase_tick), .channel_pin_in(channel_pin_in),
   .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe), .irq(irq));

/* dv/ccarr_pins.sv */
// Purpose: pin-side sources and the shared pin wire
// Assumes: sources change just after mclk edges
// Notes:   glitch input breaks the minimum level time on purpose
`timescale 1ns/1ps
module ccarr_pins #(
   parameter NCH = 6
) (
   input  wire           mclk,
   input  wire           resetn,
   input  wire [NCH-1:0] want,
   input  wire [NCH-1:0] glitch,
   input  wire [NCH-1:0] pin_out,
   input  wire [NCH-1:0] pin_oe,
   output wire [NCH-1:0] pin_in
);
   reg [NCH-1:0] lvl_r;
   reg [1:0]     age_r;
   // hold at least three clocks
   // A new level waits until the old one stood long enough
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         lvl_r <= {NCH{1'b0}};
         age_r <= 2'h0;
      end else if (want != lvl_r && age_r >= 2'h2) begin
         lvl_r <= want;
         age_r <= 2'h0;
      end else if (age_r != 2'h3) begin
         age_r <= age_r + 2'h1;
      end
   end
   // Driven pins read back the block's own level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & (lvl_r ^ glitch));
endmodule

/* dv/tb.sv */
// Purpose: self-checking bench for the capture/compare array
// Assumes: reads checked one cycle later from a queue of notes
// Notes:   counter held still except for counted ticks
`timescale 1ns/1ps
`include "ccarr_regs.vh"
module tb;
   localparam NCH = 6;
   reg           mclk, resetn, reg_wr, reg_rd, timebase_tick, rd_d;
   reg [7:0]     reg_addr, reg_wdata, mode;
   reg [NCH-1:0] want, glitch;
   reg [15:0]    base;
   wire [7:0]    reg_rdata;
   wire [NCH-1:0] pin_in, pin_out, pin_oe;
   wire          irq;
   logic [7:0]   exp_q[$];
   integer       fail_count, checks, cyc, i, j;
   ccarr_top #(.NCH(NCH)) dut_u (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .timebase_tick(timebase_tick), .channel_pin_in(pin_in),
      .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .irq(irq));
   ccarr_pins #(.NCH(NCH)) pins_u (.mclk(mclk), .resetn(resetn), .want(want),
      .glitch(glitch), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
   function [7:0] ch(input integer n, input [1:0] o);
      ch = `CCA_CH_BASE + 8'(4 * n) + {6'h0, o};
   endfunction
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      if (fail_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask
   task wr16(input [7:0] a, input [15:0] v);
      wr(a, v[7:0]);
      wr(a + 8'h1, v[15:8]);
   endtask
   task rd16(input [7:0] a, input [15:0] v);
      rd(a, v[7:0]);
      rd(a + 8'h1, v[15:8]);
   endtask
   task ticks(input integer n);
      repeat (n) begin
         @(posedge mclk);
         timebase_tick <= 1'b1;
      end
      @(posedge mclk);
      timebase_tick <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   // Scoreboard: the read answer stands one cycle after the strobe
   always @(posedge mclk) begin
      if (rd_d)
         chk(reg_rdata, exp_q.pop_front());
      rd_d <= reg_rd;
   end
   // Hang guard, far above the expected run length
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         report_and_stop;
      end
   end
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      {resetn, reg_wr, reg_rd, timebase_tick, rd_d} = 5'h0;
      {reg_addr, reg_wdata, want, glitch} = 0;
      {fail_count, checks, cyc} = 0;
      i = $urandom(32'h985af66c);
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      rd(`CCA_CTRL_OFF, 8'h00);
      rd(8'h04, 8'h00);
      rd(ch(0, `CCA_CH_MODE), 8'h00);
      // Software timer on a random compare value
      base = {8'($urandom), 8'h40};
      wr(`CCA_CTRL_OFF, 8'h01);
      wr(ch(0, `CCA_CH_MODE), 8'h48);
      wr(ch(0, `CCA_CH_LOW), base[7:0]);
      rd(ch(0, `CCA_CH_MODE), 8'h08);
      wr(ch(0, `CCA_CH_HIGH), base[15:8]);
      rd(ch(0, `CCA_CH_MODE), 8'h48);
      wr16(`CCA_CNTL_OFF, base - 16'h4);
      ticks(3);
      rd(`CCA_FLAGS_OFF, 8'h00);
      ticks(3);
      rd(`CCA_FLAGS_OFF, 8'h01);
      rd16(`CCA_CNTL_OFF, base + 16'h2);
      chk({7'h0, irq}, 8'h00);
      wr(`CCA_CTRL_OFF, 8'h03);
      wr(ch(0, `CCA_CH_MODE), 8'h49);
      repeat (2) @(posedge mclk);
      chk({7'h0, irq}, 8'h00);
      wr(`CCA_CTRL_OFF, 8'h07);
      repeat (4) @(posedge mclk);
      chk({7'h0, irq}, 8'h01);
      wr(`CCA_FLAGS_OFF, 8'h01);
      repeat (2) @(posedge mclk);
      chk({7'h0, irq}, 8'h00);
      wr(ch(0, `CCA_CH_MODE), 8'h00);
      // Partial wrap for each cycle length code, then full wrap
      for (i = 0; i < 4; i = i + 1) begin
         wr(`CCA_PWMCFG_OFF, i[7:0]);
         wr16(`CCA_CNTL_OFF, 16'((32'h1 << (8 + i)) - 2));
         wr(`CCA_FLAGS_OFF, 8'hff);
         ticks(1);
         rd(`CCA_FLAGS_OFF, 8'h00);
         ticks(1);
         rd(`CCA_FLAGS_OFF, 8'h80);
      end
      wr16(`CCA_CNTL_OFF, 16'hfffe);
      wr(`CCA_FLAGS_OFF, 8'hff);
      ticks(2);
      rd(`CCA_FLAGS_OFF, 8'hc0);
      rd16(`CCA_CNTL_OFF, 16'h0000);
      // Capture: rise only, fall only, either edge
      for (i = 0; i < 3; i = i + 1) begin
         mode = (i == 0) ? 8'h20 : (i == 1) ? 8'h10 : 8'h30;
         wr(ch(1, `CCA_CH_MODE), mode);
         for (j = 0; j < 2; j = j + 1) begin
            base = 16'($urandom);
            wr16(`CCA_CNTL_OFF, base);
            wr(`CCA_FLAGS_OFF, 8'hff);
            want[1] <= ~want[1];
            repeat (6) @(posedge mclk);
            rd(`CCA_FLAGS_OFF, {6'h0, mode[5 - j], 1'b0});
            if (mode[5 - j])
               rd16(ch(1, `CCA_CH_LOW), base);
         end
      end
      wr(`CCA_FLAGS_OFF, 8'hff);
      glitch[1] <= 1'b1;
      @(posedge mclk);
      glitch[1] <= 1'b0;
      repeat (6) @(posedge mclk);
      rd(`CCA_FLAGS_OFF, 8'h00);
      // Toggle on match, then hold with the comparator off
      wr(ch(2, `CCA_CH_MODE), 8'h4c);
      wr16(ch(2, `CCA_CH_LOW), 16'h0005);
      wr16(`CCA_CNTL_OFF, 16'h0003);
      wr(`CCA_FLAGS_OFF, 8'hff);
      ticks(3);
      chk({6'h0, pin_oe[2], pin_out[2]}, 8'h03);
      rd(`CCA_FLAGS_OFF, 8'h04);
      wr(ch(2, `CCA_CH_LOW), 8'h05);
      wr16(`CCA_CNTL_OFF, 16'h0004);
      ticks(2);
      chk({6'h0, pin_oe[2], pin_out[2]}, 8'h03);
      // Frequency output, step 4 then step of 256
      wr(ch(3, `CCA_CH_MODE), 8'h46);
      wr16(ch(3, `CCA_CH_LOW), 16'h0410);
      wr16(`CCA_CNTL_OFF, 16'h0000);
      wr(`CCA_FLAGS_OFF, 8'hff);
      ticks(17);
      chk({7'h0, pin_out[3]}, 8'h01);
      rd(ch(3, `CCA_CH_LOW), 8'h14);
      ticks(4);
      chk({7'h0, pin_out[3]}, 8'h00);
      rd(`CCA_FLAGS_OFF, 8'h00);
      wr16(ch(3, `CCA_CH_LOW), 16'h0020);
      ticks(12);
      chk({7'h0, pin_out[3]}, 8'h01);
      ticks(255);
      chk({7'h0, pin_out[3]}, 8'h01);
      ticks(1);
      chk({7'h0, pin_out[3]}, 8'h00);
      // Pulse width: comparator off, match flags, reload view
      wr(`CCA_PWMCFG_OFF, 8'h00);
      wr(ch(4, `CCA_CH_MODE), 8'h0a);
      ticks(300);
      chk({6'h0, pin_oe[4], pin_out[4]}, 8'h02);
      wr16(ch(4, `CCA_CH_LOW), 16'h8080);
      wr(`CCA_FLAGS_OFF, 8'hff);
      ticks(256);
      rd(`CCA_FLAGS_OFF, 8'h90);
      wr(`CCA_PWMCFG_OFF, 8'h81);
      wr(ch(4, `CCA_CH_LOW), 8'h55);
      rd(ch(4, `CCA_CH_LOW), 8'h55);
      wr(`CCA_PWMCFG_OFF, 8'h01);
      rd(ch(4, `CCA_CH_LOW), 8'h80);
      repeat (4) @(posedge mclk);
      report_and_stop;
   end
endmodule
